// ### hw/urs_pkg.sv
// Package for the serial receive status block: register map, fields,
// reset values, oversampling figures and the buffered character type.
// Assumes a 32-bit APB register bus with byte addresses.
package urs_pkg;
    localparam int unsigned ADDR_W = 12;
    localparam int unsigned DATA_W = 32;
    localparam logic [11:0] STATUS_OFS = 12'h000;
    localparam logic [11:0] MODE_OFS = 12'h004;
    localparam logic [11:0] BAUD_OFS = 12'h008;
    localparam logic [11:0] RXDATA_OFS = 12'h00c;
    localparam int unsigned IRQSEL_POS = 6;
    localparam int unsigned ADDRESS_DETECT_ENABLE_POS = 5;
    localparam int unsigned IDLE_POS = 4;
    localparam int unsigned PARITY_ERROR_FLAG_POS = 3;
    localparam int unsigned FRAMING_ERROR_FLAG_POS = 2;
    localparam int unsigned OVERRUN_ERROR_FLAG_POS = 1;
    localparam int unsigned RXDA_POS = 0;
    localparam logic [1:0] IRQSEL_RST = 2'h0;
    localparam logic ADDRESS_DETECT_ENABLE_RST = 1'b0;
    localparam logic [1:0] MODE_RST = 2'h0;
    localparam logic [15:0] BAUD_RST = 16'h0040;
    // Character formats held in the mode register
    localparam logic [1:0] MODE_8N = 2'h0;
    localparam logic [1:0] MODE_8E = 2'h1;
    localparam logic [1:0] MODE_8O = 2'h2;
    localparam logic [1:0] MODE_9N = 2'h3;
    localparam logic [1:0] IRQ_ON_FULL = 2'h3;
    localparam logic [1:0] IRQ_ON_3 = 2'h2;
    localparam logic [3:0] TICK_MID = 4'h7;
    localparam logic [3:0] TICK_LAST = 4'hf;
    localparam logic [3:0] BITS_8 = 4'h7;
    localparam logic [3:0] BITS_9 = 4'h8;
    typedef struct packed {
        logic parity_error_flag;
        logic framing_error_flag;
        logic [8:0] data;
    } urs_entry_t;
endpackage

// ### hw/urs_rx_status.sv
// Serial receiver with status/control register, receive buffer and
// address detect. Expects an APB master on pclk and an async rx line.
`timescale 1ns/1ps
//
// Overview of operation
// (RL1) Address detect only in 9-bit mode
// (RL2) Idle flag reads one when receiver idle
// (RL3) Parity flag reflects head-of-buffer character
// (RL4) Framing flag reflects head-of-buffer character
// (RL5) Overrun set by overflow, never by software
// (RL6) Clearing overrun empties buffer and shifter
// (RL7) Data-available flag means buffer not empty
// (RL8) Receive interrupt follows the select code
// (RL9) Errors stored per character, follow head
module urs_rx_status #(
    parameter int unsigned DEPTH = 4
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [urs_pkg::ADDR_W-1:0] paddr,
    input wire logic [urs_pkg::DATA_W-1:0] pwdata,
    output logic [urs_pkg::DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic rx_pin,
    output logic rx_irq
);
    import urs_pkg::*;
    localparam int unsigned PTR_W = $clog2(DEPTH);
    localparam int unsigned CNT_W = PTR_W + 1;
    localparam logic [CNT_W-1:0] FULL_CNT = CNT_W'(DEPTH);
    localparam logic [CNT_W-1:0] THREE_CNT = CNT_W'(3);

    generate
        if (DEPTH < 4 || (DEPTH & (DEPTH - 1)) != 0)
        begin : g_bad_depth
            $error("DEPTH must be a power of two, at least 4");
        end
    endgenerate

    typedef enum logic [2:0] {
        RX_IDLE, RX_START, RX_DATA, RX_PARITY, RX_STOP
    } urs_rx_state_t;

    // Pin synchroniser
    logic rx_meta_r, rx_s_r;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rx_meta_r <= 1'b1;
            rx_s_r <= 1'b1;
        end
        else
        begin
            rx_meta_r <= rx_pin;
            rx_s_r <= rx_meta_r;
        end
    end

    // Line-side state
    urs_rx_state_t st_r, st_nxt;
    logic [15:0] baud_cnt_r, baud_cnt_nxt;
    logic [3:0] tick_cnt_r, tick_cnt_nxt;
    logic [3:0] bit_cnt_r, bit_cnt_nxt;
    logic [8:0] shift_r, shift_nxt;
    logic parity_error_flag_r, parity_error_flag_nxt;
    logic done;
    urs_entry_t rx_char;
    // Register-side state
    urs_entry_t mem [DEPTH];
    logic [PTR_W-1:0] wr_ptr_r, wr_ptr_nxt, rd_ptr_r, rd_ptr_nxt;
    logic [CNT_W-1:0] count_r, count_nxt;
    logic overrun_error_flag_r, overrun_error_flag_nxt, address_detect_enable_r, address_detect_enable_nxt;
    logic [1:0] irqsel_r, irqsel_nxt, mode_r, mode_nxt;
    logic [15:0] baud_div_r, baud_div_nxt;
    logic [DATA_W-1:0] prdata_r, prdata_nxt;
    logic rd_pop_r, rd_pop_nxt, irq_r, irq_nxt;
    logic push_valid, push_ready, push, pop, overflow, flush;
    logic setup, access, mapped, has_data, addr_mode, tick;
    logic [CNT_W-1:0] count_after;
    logic [DATA_W-1:0] status_val;
    urs_entry_t head;

    assign tick = (baud_cnt_r == 16'h0000);
    assign head = mem[rd_ptr_r];
    assign has_data = (count_r != '0);

    always_comb
    begin
        st_nxt = st_r;
        tick_cnt_nxt = tick_cnt_r;
        bit_cnt_nxt = bit_cnt_r;
        shift_nxt = shift_r;
        parity_error_flag_nxt = parity_error_flag_r;
        baud_cnt_nxt = tick ? baud_div_r : baud_cnt_r - 16'h0001;
        done = 1'b0;
        unique case (st_r)
            RX_IDLE:
            begin
                if (!rx_s_r)
                begin
                    st_nxt = RX_START;
                    tick_cnt_nxt = '0;
                end
            end
            RX_START:
            begin
                if (tick && tick_cnt_r == TICK_MID)
                begin
                    st_nxt = rx_s_r ? RX_IDLE : RX_DATA;
                    tick_cnt_nxt = '0;
                    bit_cnt_nxt = '0;
                    shift_nxt = '0;
                    parity_error_flag_nxt = 1'b0;
                end
                else if (tick)
                    tick_cnt_nxt = tick_cnt_r + 4'h1;
            end
            RX_DATA, RX_PARITY, RX_STOP:
            begin
                if (tick && tick_cnt_r == TICK_LAST)
                begin
                    tick_cnt_nxt = '0;
                    if (st_r == RX_DATA)
                    begin
                        shift_nxt = {rx_s_r, shift_r[8:1]};
                        bit_cnt_nxt = bit_cnt_r + 4'h1;
                        if (bit_cnt_r
                            == ((mode_r == MODE_9N) ? BITS_9 : BITS_8))
                            st_nxt = (mode_r == MODE_8E || mode_r == MODE_8O)
                                ? RX_PARITY : RX_STOP;
                    end
                    else if (st_r == RX_PARITY)
                    begin
                        parity_error_flag_nxt = (^shift_r[8:1]) ^ rx_s_r
                            ^ (mode_r == MODE_8O);
                        st_nxt = RX_STOP;
                    end
                    else
                    begin
                        done = 1'b1;
                        st_nxt = RX_IDLE;
                    end
                end
                else if (tick)
                    tick_cnt_nxt = tick_cnt_r + 4'h1;
            end
        endcase
        if (flush)
        begin
            st_nxt = RX_IDLE; // [RL6]
            shift_nxt = '0;
            tick_cnt_nxt = '0;
            bit_cnt_nxt = '0;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st_r <= RX_IDLE;
            baud_cnt_r <= BAUD_RST;
            tick_cnt_r <= '0;
            bit_cnt_r <= '0;
            shift_r <= '0;
            parity_error_flag_r <= 1'b0;
        end
        else
        begin
            st_r <= st_nxt;
            baud_cnt_r <= baud_cnt_nxt;
            tick_cnt_r <= tick_cnt_nxt;
            bit_cnt_r <= bit_cnt_nxt;
            shift_r <= shift_nxt;
            parity_error_flag_r <= parity_error_flag_nxt;
        end
    end

    // Finished character with its own error bits
    always_comb
    begin
        rx_char.parity_error_flag = parity_error_flag_r; // [RL9]
        rx_char.framing_error_flag = !rx_s_r; // [RL9]
        rx_char.data = (mode_r == MODE_9N) ? shift_r : {1'b0, shift_r[8:1]};
    end

    assign addr_mode = address_detect_enable_r && (mode_r == MODE_9N); // [RL1]
    assign push_valid = done && !overrun_error_flag_r
        && (!addr_mode || rx_char.data[8]); // [RL1]
    assign push_ready = (count_r != FULL_CNT);
    assign push = push_valid && push_ready;
    assign overflow = done && !overrun_error_flag_r && (!addr_mode || rx_char.data[8])
        && !push_ready;
    assign setup = psel && !penable;
    assign access = psel && penable;
    assign mapped = (paddr == STATUS_OFS) || (paddr == MODE_OFS)
        || (paddr == BAUD_OFS) || (paddr == RXDATA_OFS);
    assign pop = access && !pwrite && (paddr == RXDATA_OFS) && rd_pop_r;
    // Set wins: an overflow in the clearing cycle keeps the flag, no flush
    assign flush = access && pwrite && (paddr == STATUS_OFS) && overrun_error_flag_r
        && !pwdata[OVERRUN_ERROR_FLAG_POS] && !overflow; // [RL6]
    assign count_after = count_r + CNT_W'(1) - CNT_W'(pop);

    always_comb
    begin
        status_val = '0;
        status_val[IRQSEL_POS+1:IRQSEL_POS] = irqsel_r;
        status_val[ADDRESS_DETECT_ENABLE_POS] = address_detect_enable_r;
        status_val[IDLE_POS] = (st_r == RX_IDLE); // [RL2]
        status_val[PARITY_ERROR_FLAG_POS] = has_data && head.parity_error_flag; // [RL3] [RL9]
        status_val[FRAMING_ERROR_FLAG_POS] = has_data && head.framing_error_flag; // [RL4] [RL9]
        status_val[OVERRUN_ERROR_FLAG_POS] = overrun_error_flag_r;
        status_val[RXDA_POS] = has_data; // [RL7]
    end

    always_comb
    begin
        wr_ptr_nxt = wr_ptr_r + PTR_W'(push);
        rd_ptr_nxt = rd_ptr_r + PTR_W'(pop); // [RL9]
        count_nxt = count_r + CNT_W'(push) - CNT_W'(pop);
        overrun_error_flag_nxt = overrun_error_flag_r || overflow; // [RL5]
        address_detect_enable_nxt = address_detect_enable_r;
        irqsel_nxt = irqsel_r;
        mode_nxt = mode_r;
        baud_div_nxt = baud_div_r;
        prdata_nxt = prdata_r;
        rd_pop_nxt = rd_pop_r;
        irq_nxt = 1'b0;
        if (push)
        begin
            unique case (irqsel_r)
                IRQ_ON_FULL: irq_nxt = (count_after == FULL_CNT); // [RL8]
                IRQ_ON_3: irq_nxt = (count_after == THREE_CNT); // [RL8]
                default: irq_nxt = 1'b1; // [RL8]
            endcase
        end
        if (setup && !pwrite)
        begin
            rd_pop_nxt = (paddr == RXDATA_OFS) && has_data;
            unique case (paddr)
                STATUS_OFS: prdata_nxt = status_val;
                MODE_OFS: prdata_nxt = {30'h0, mode_r};
                BAUD_OFS: prdata_nxt = {16'h0, baud_div_r};
                RXDATA_OFS: prdata_nxt = has_data
                    ? {23'h0, head.data} : '0;
                default: prdata_nxt = '0;
            endcase
        end
        if (access && pwrite)
        begin
            unique case (paddr)
                STATUS_OFS:
                begin
                    irqsel_nxt = pwdata[IRQSEL_POS+1:IRQSEL_POS];
                    address_detect_enable_nxt = pwdata[ADDRESS_DETECT_ENABLE_POS];
                end
                MODE_OFS: mode_nxt = pwdata[1:0];
                BAUD_OFS: baud_div_nxt = pwdata[15:0];
                default: ;
            endcase
        end
        if (flush)
        begin
            overrun_error_flag_nxt = 1'b0; // [RL5]
            wr_ptr_nxt = '0; // [RL6]
            rd_ptr_nxt = '0;
            count_nxt = '0;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r <= '0;
            overrun_error_flag_r <= 1'b0;
            address_detect_enable_r <= ADDRESS_DETECT_ENABLE_RST;
            irqsel_r <= IRQSEL_RST;
            mode_r <= MODE_RST;
            baud_div_r <= BAUD_RST;
            prdata_r <= '0;
            rd_pop_r <= 1'b0;
            irq_r <= 1'b0;
        end
        else
        begin
            wr_ptr_r <= wr_ptr_nxt;
            rd_ptr_r <= rd_ptr_nxt;
            count_r <= count_nxt;
            overrun_error_flag_r <= overrun_error_flag_nxt;
            address_detect_enable_r <= address_detect_enable_nxt;
            irqsel_r <= irqsel_nxt;
            mode_r <= mode_nxt;
            baud_div_r <= baud_div_nxt;
            prdata_r <= prdata_nxt;
            rd_pop_r <= rd_pop_nxt;
            irq_r <= irq_nxt;
        end
    end

    always_ff @(posedge pclk)
    begin
        if (push)
            mem[wr_ptr_r] <= rx_char; // [RL9]
    end

    assign prdata = prdata_r;
    assign pready = 1'b1;
    assign pslverr = access && !mapped;
    assign rx_irq = irq_r;

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    addr_filter_a: assert property ( // [RL1]
        push |-> !(addr_mode && !rx_char.data[8]))
        else $error("non-address character stored in address mode");
    mode_noeffect_a: assert property ( // [RL1]
        done && mode_r != MODE_9N && !overrun_error_flag_r && push_ready |-> push)
        else $error("character dropped outside 9-bit mode");
    idle_flag_a: assert property ( // [RL2]
        st_r == RX_IDLE && !rx_s_r && !flush
        |=> !status_val[IDLE_POS] ##1 !status_val[IDLE_POS])
        else $error("idle flag high during reception");
    parity_error_flag_head_a: assert property ( // [RL3]
        push && rx_char.parity_error_flag && !has_data |=> status_val[PARITY_ERROR_FLAG_POS])
        else $error("parity flag missing for head character");
    framing_error_flag_head_a: assert property ( // [RL4]
        push && rx_char.framing_error_flag && !has_data |=> status_val[FRAMING_ERROR_FLAG_POS])
        else $error("framing flag missing for head character");
    overrun_error_flag_set_a: assert property (overflow |=> overrun_error_flag_r) // [RL5]
        else $error("overflow did not set overrun flag");
    overrun_error_flag_noset_a: assert property (!overrun_error_flag_r && !overflow |=> !overrun_error_flag_r) // [RL5]
        else $error("overrun flag set without overflow");
    flush_clear_a: assert property ( // [RL6]
        flush |=> !has_data && st_r == RX_IDLE && !overrun_error_flag_r)
        else $error("overrun clear did not empty receiver");
    rxda_flag_a: assert property ( // [RL7]
        push && !has_data |=> status_val[RXDA_POS]
        ##0 $past(status_val[RXDA_POS]) == 1'b0)
        else $error("data available flag wrong");
    irq_full_a: assert property ( // [RL8]
        push && irqsel_r == IRQ_ON_FULL && count_r == FULL_CNT - CNT_W'(1)
        && !pop |=> rx_irq)
        else $error("full interrupt missing");
    irq_quiet_a: assert property ( // [RL8]
        push && irqsel_r == IRQ_ON_FULL && count_r == '0 |=> !rx_irq)
        else $error("full interrupt fired early");
    head_adv_a: assert property ( // [RL9]
        pop && count_r == CNT_W'(1) && !push
        |=> !status_val[PARITY_ERROR_FLAG_POS] && !status_val[FRAMING_ERROR_FLAG_POS])
        else $error("error flags not following head");
endmodule // urs_rx_status

// ### testbench/urs_line_model.sv
// Far-end serial transmitter model driving the receive line.
// Assumes the baud divisor is 0: one bit lasts BIT_CYC clock cycles.
`timescale 1ns/1ps
module urs_line_model #(
    parameter int BIT_CYC = 16
) (
    input wire logic clk,
    output logic line
);
    initial line = 1'b1;

    // Frame: start, LSB first data, optional parity, stop, one idle bit
    task automatic send(input logic [8:0] d, input int nb, input int pm,
        input logic flip, input logic stopv);
        logic p;
        int i;
        p = (pm == 2) ? ~^d[7:0] : ^d[7:0];
        p = p ^ flip;
        @(posedge clk);
        line <= 1'b0;
        repeat (BIT_CYC) @(posedge clk);
        for (i = 0; i < nb; i++)
        begin
            line <= d[i];
            repeat (BIT_CYC) @(posedge clk);
        end
        if (pm != 0)
        begin
            line <= p;
            repeat (BIT_CYC) @(posedge clk);
        end
        line <= stopv;
        repeat (BIT_CYC) @(posedge clk);
        // Line idles high between frames
        line <= 1'b1;
        repeat (BIT_CYC) @(posedge clk);
    endtask
endmodule // urs_line_model

// ### testbench/test_uart_receive_status.sv
// Self-checking bench for the serial receive status block.
// Assumes zero-wait APB slave and the line model on rx_pin.
`timescale 1ns/1ps
module test_uart_receive_status;
    import urs_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [ADDR_W-1:0] paddr = '0;
    logic [DATA_W-1:0] pwdata = '0;
    logic [DATA_W-1:0] prdata;
    logic pready;
    logic pslverr;
    logic rx_irq;
    wire logic rx_line;
    logic [31:0] rdata;
    logic rerr;
    int n_errors = 0;
    int n_compared = 0;
    int n_irq = 0;
    int i;

    urs_rx_status #(.DEPTH(4)) dut_u (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .rx_pin(rx_line), .rx_irq(rx_irq));
    urs_line_model #(.BIT_CYC(16)) tx_u (.clk(pclk), .line(rx_line));

    initial forever #50 pclk = ~pclk;
    always @(posedge pclk) if (rx_irq === 1'b1) n_irq <= n_irq + 1;

    task automatic apb(input logic w, input logic [11:0] a,
        input logic [31:0] wd);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
        begin
            @(posedge pclk);
        end
        rdata = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000);
        check(rdata, exp);
    endtask

    task automatic summarize();
        $display("compared %0d, mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    initial
    begin
        repeat (20000) @(posedge pclk);
        n_errors++;
        $display("ERROR %0t: timeout", $time);
        summarize();
    end

    initial
    begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rd(STATUS_OFS, 32'h0000_0010);
        rd(MODE_OFS, 32'h0000_0000);
        rd(BAUD_OFS, 32'h0000_0040);
        check(rerr, 32'h0000_0000);
        rd(12'h010, 32'h0000_0000);
        check(rerr, 32'h0000_0001);
        wr(BAUD_OFS, 32'h0000_0000);
        // Let the baud counter run out its reset divisor first
        repeat (64) @(posedge pclk);
        $display("test reset done");

        fork
            tx_u.send(9'h0a5, 8, 0, 1'b0, 1'b1);
            begin
                repeat (40) @(posedge pclk);
                rd(STATUS_OFS, 32'h0000_0000);
            end
        join
        rd(STATUS_OFS, 32'h0000_0011);
        check(n_irq, 32'h0000_0001);
        rd(RXDATA_OFS, 32'h0000_00a5);
        rd(STATUS_OFS, 32'h0000_0010);
        $display("test receive done");

        wr(MODE_OFS, {30'h0, MODE_8E});
        tx_u.send(9'h003, 8, 1, 1'b1, 1'b1);
        tx_u.send(9'h003, 8, 1, 1'b0, 1'b1);
        tx_u.send(9'h005, 8, 1, 1'b0, 1'b0);
        rd(STATUS_OFS, 32'h0000_0019);
        rd(RXDATA_OFS, 32'h0000_0003);
        rd(STATUS_OFS, 32'h0000_0011);
        rd(RXDATA_OFS, 32'h0000_0003);
        rd(STATUS_OFS, 32'h0000_0015);
        rd(RXDATA_OFS, 32'h0000_0005);
        rd(STATUS_OFS, 32'h0000_0010);
        check(n_irq, 32'h0000_0004);
        $display("test errors done");

        wr(MODE_OFS, {30'h0, MODE_8O});
        tx_u.send(9'h003, 8, 2, 1'b0, 1'b0);
        rd(STATUS_OFS, 32'h0000_0015);
        rd(RXDATA_OFS, 32'h0000_0003);
        wr(MODE_OFS, {30'h0, MODE_8N});
        wr(STATUS_OFS, 32'h0000_0080);
        for (i = 0; i < 3; i++) tx_u.send(9'h010 + i, 8, 0, 1'b0, 1'b1);
        check(n_irq, 32'h0000_0006);
        wr(STATUS_OFS, 32'h0000_00c2);
        tx_u.send(9'h013, 8, 0, 1'b0, 1'b1);
        check(n_irq, 32'h0000_0007);
        rd(STATUS_OFS, 32'h0000_00d1);
        tx_u.send(9'h014, 8, 0, 1'b0, 1'b1);
        rd(STATUS_OFS, 32'h0000_00d3);
        check(n_irq, 32'h0000_0007);
        wr(STATUS_OFS, 32'h0000_00c0);
        rd(STATUS_OFS, 32'h0000_00d0);
        rd(RXDATA_OFS, 32'h0000_0000);
        tx_u.send(9'h015, 8, 0, 1'b0, 1'b1);
        check(n_irq, 32'h0000_0007);
        rd(RXDATA_OFS, 32'h0000_0015);
        $display("test overrun done");

        wr(STATUS_OFS, 32'h0000_0060);
        wr(MODE_OFS, {30'h0, MODE_9N});
        tx_u.send(9'h055, 9, 0, 1'b0, 1'b1);
        rd(STATUS_OFS, 32'h0000_0070);
        tx_u.send(9'h1aa, 9, 0, 1'b0, 1'b1);
        rd(STATUS_OFS, 32'h0000_0071);
        rd(RXDATA_OFS, 32'h0000_01aa);
        wr(MODE_OFS, {30'h0, MODE_8N});
        tx_u.send(9'h055, 8, 0, 1'b0, 1'b1);
        rd(RXDATA_OFS, 32'h0000_0055);
        check(n_irq, 32'h0000_0009);
        $display("test address done");
        summarize();
    end
endmodule // test_uart_receive_status
